/* File: cirq_pkg.sv */
// Package of register map, field positions and reset values for the interrupt request logic
package cirq_pkg;

  // ==========================================================
  // Register indices and byte addresses
  localparam logic [3:0] IDX_PRI_EN   = 4'h2;
  localparam logic [3:0] IDX_SEC_EN   = 4'h3;
  localparam logic [3:0] IDX_PRI_REQ  = 4'h4;
  localparam logic [3:0] IDX_SEC_REQ  = 4'h5;
  localparam logic [3:0] IDX_STATUS   = 4'h7;
  localparam logic [3:0] IDX_CONTROL  = 4'h8;
  localparam int         ADDR_LSB     = 2;
  localparam int         ADDR_W       = 6;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_PRI_EN   = 8'h80;
  localparam logic [7:0] RST_SEC_EN   = 8'h00;
  localparam logic [7:0] RST_PRI_REQ  = 8'h14;
  localparam logic [7:0] RST_SEC_REQ  = 8'h00;
  localparam logic [7:0] RST_CONTROL  = 8'h00;

  // ==========================================================
  // Field positions
  localparam int POS_POLARITY     = 7;
  localparam int POS_INVERT       = 7;
  localparam int POS_SEND_DONE    = 6;
  localparam int POS_RECV_DONE    = 5;
  localparam int POS_CMD_FINISHED = 4;
  localparam int POS_FIFO_HIGH    = 3;
  localparam int POS_FIFO_LOW     = 2;
  localparam int POS_FAULT        = 1;
  localparam int POS_COUNTDOWN    = 0;
  localparam int POS_DRIVE_STYLE  = 7;
  localparam int POS_AUX_EDGE     = 4;
  localparam int POS_MODE_FOUND   = 3;
  localparam int POS_CHECKSUM     = 2;
  localparam int POS_FIELD_APPEAR = 1;
  localparam int POS_FIELD_VANISH = 0;
  localparam int POS_STAT_IRQ     = 4;
  localparam int POS_STAT_MODE    = 5;
  localparam int POS_CTRL_CLEAN   = 0;

  // Writable bits of the secondary enable and the two request registers
  localparam logic [7:0] MASK_SEC_EN  = 8'h9F;
  localparam logic [6:0] MASK_PRI_REQ = 7'h7F;
  localparam logic [6:0] MASK_SEC_REQ = 7'h1F;

  // ==========================================================
  // Command codes of the sequencer
  localparam logic [3:0] CMD_IDLE     = 4'h0;
  localparam logic [3:0] CMD_CHECKSUM = 4'h3;
  localparam logic [3:0] CMD_AUTO_ANTICOLLISION_COMMAND = 4'hD;

  // AXI responses
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

endpackage

/* File: cirq_top.sv */
// Interrupt request latches, enables, pin driver and AXI4-Lite register slave
// Notes on behaviour
// - Drive-style bit 1 makes the pin push-pull, 0 makes it open drain.
// - Secondary enable bits 4..0 gate aux, mode, checksum, field-on, field-off.
// - Primary request write: bit 7 high sets marked bits, low clears them.
// - Secondary request write: bit 7 high sets marked bits, low clears them.
// - Send-done flag sets right after the last transmitted bit.
// - Receive-done flag sets at end of a valid incoming stream.
// - With clean-only option, receive-done needs data present in the FIFO.
// - Command-finished flag sets when a command returns to idle by itself.
// - An unknown command returns to idle and sets command-finished.
// - Host writing the idle command does not set command-finished.
// - FIFO high flag latches on rising high status, held until cleared.
// - FIFO low flag latches on rising low status, held until cleared.
// - Fault flag sets while any error register bit is set.
// - Countdown flag sets when the timer reaches zero.
// - Aux flag sets on either edge of the aux serial input.
// - Mode-found flag sets when the mode detector recognises the mode.
// - Mode detector starts on auto anticollision, stops on detect, restarts on RF reset while in auto anticollision.
// - Checksum flag sets when checksum command is active and data processed.
// - Field-appear flag sets when an external field is detected.
// - Field-vanish flag sets when a present external field goes away.
// - Primary request resets to 14h, secondary enable to 00h.
// - Invert bit 1 makes the pin the inverse of the combined status.
// - Primary enable bits 6..0 gate the seven primary requests.
//
// Chosen here: the AXI4-Lite slave port.
module cirq_top
  import cirq_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                clk_en,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Event sources, same clock
  input  wire logic                send_last_bit,
  input  wire logic                receive_stream_end,
  input  wire logic                fifo_has_data,
  input  wire logic [3:0]          command_field,
  input  wire logic                host_idle_write,
  input  wire logic                unknown_command_start,
  input  wire logic                fifo_high_status,
  input  wire logic                fifo_low_status,
  input  wire logic [7:0]          error_bits,
  input  wire logic                countdown_reached_zero,
  input  wire logic                mode_detected,
  input  wire logic                rf_reset,
  input  wire logic                checksum_all_processed,
  input  wire logic                rf_field_present,
  // Asynchronous pin
  input  wire logic                aux_serial_input,
  // Outputs
  output logic                     mode_detector_run,
  output logic                     irq_pin_out,
  output logic                     irq_pin_oe_n
);

  // ==========================================================
  // State
  logic [7:0] pri_en_q;
  logic [7:0] sec_en_q;
  logic [6:0] pri_req_q;
  logic [6:0] pri_req_d;
  logic [4:0] sec_req_q;
  logic [4:0] sec_req_d;
  logic [7:0] control_q;
  logic       aux_sync1_q;
  logic       aux_sync2_q;
  logic       aux_prev_q;
  logic [3:0] cmd_prev_q;
  logic       high_prev_q;
  logic       low_prev_q;
  logic       field_prev_q;
  logic       mode_run_q;
  logic       irq_q;
  logic       pin_out_q;
  logic       pin_oe_n_q;
  logic       awready_q;
  logic       wready_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;
  logic [3:0] aw_idx_q;
  logic [7:0] wdata_q;
  logic       wstrb0_q;
  logic       arready_q;
  logic       rvalid_q;
  logic [1:0] rresp_q;
  logic [7:0] rdata_q;

  // ==========================================================
  // Bus decode
  wire        aw_take    = s_axi_awvalid & awready_q;
  wire        w_take     = s_axi_wvalid & wready_q;
  wire        b_done     = bvalid_q & s_axi_bready;
  wire        ar_take    = s_axi_arvalid & arready_q;
  wire        r_done     = rvalid_q & s_axi_rready;
  wire        write_fire = ~awready_q & ~wready_q & ~bvalid_q;
  wire [3:0]  ar_idx     = s_axi_araddr[ADDR_LSB +: 4];

  wire        wr_mapped  = (aw_idx_q == IDX_PRI_EN)  | (aw_idx_q == IDX_SEC_EN) |
                           (aw_idx_q == IDX_PRI_REQ) | (aw_idx_q == IDX_SEC_REQ) |
                           (aw_idx_q == IDX_STATUS)  | (aw_idx_q == IDX_CONTROL);
  // Byte lane 0 carries every register; other lanes are ignored
  wire        wr_ok      = write_fire & wstrb0_q;
  wire        wr_pri_en  = wr_ok & (aw_idx_q == IDX_PRI_EN);
  wire        wr_sec_en  = wr_ok & (aw_idx_q == IDX_SEC_EN);
  wire        wr_pri_req = wr_ok & (aw_idx_q == IDX_PRI_REQ);
  wire        wr_sec_req = wr_ok & (aw_idx_q == IDX_SEC_REQ);
  wire        wr_control = wr_ok & (aw_idx_q == IDX_CONTROL);

  // ==========================================================
  // Event detection
  // Only the second synchroniser stage feeds the edge detector
  wire        aux_edge    = aux_sync2_q ^ aux_prev_q;
  wire        clean_only  = control_q[POS_CTRL_CLEAN];
  wire        recv_set    = receive_stream_end & (~clean_only | fifo_has_data);
  // Host-written idle is not a self-termination
  wire        cmd_to_idle = (cmd_prev_q != CMD_IDLE) & (command_field == CMD_IDLE) &
                            ~host_idle_write;
  wire        finish_set  = cmd_to_idle | unknown_command_start;
  wire        high_set    = fifo_high_status & ~high_prev_q;
  wire        low_set     = fifo_low_status & ~low_prev_q;
  wire        fault_set   = |error_bits;
  wire        mode_set    = mode_run_q & mode_detected;
  wire        crc_set     = (command_field == CMD_CHECKSUM) & checksum_all_processed;
  wire        appear_set  = rf_field_present & ~field_prev_q;
  wire        vanish_set  = ~rf_field_present & field_prev_q;
  // Entry into anticollision arms the detector once, not on every cycle spent in it
  wire        auto_anticollision_command_go = (command_field == CMD_AUTO_ANTICOLLISION_COMMAND) & (cmd_prev_q != CMD_AUTO_ANTICOLLISION_COMMAND);

  wire [6:0]  pri_hw_set;
  wire [4:0]  sec_hw_set;
  assign pri_hw_set[POS_SEND_DONE]    = send_last_bit;
  assign pri_hw_set[POS_RECV_DONE]    = recv_set;
  assign pri_hw_set[POS_CMD_FINISHED] = finish_set;
  assign pri_hw_set[POS_FIFO_HIGH]    = high_set;
  assign pri_hw_set[POS_FIFO_LOW]     = low_set;
  assign pri_hw_set[POS_FAULT]        = fault_set;
  assign pri_hw_set[POS_COUNTDOWN]    = countdown_reached_zero;
  assign sec_hw_set[POS_AUX_EDGE]     = aux_edge;
  assign sec_hw_set[POS_MODE_FOUND]   = mode_set;
  assign sec_hw_set[POS_CHECKSUM]     = crc_set;
  assign sec_hw_set[POS_FIELD_APPEAR] = appear_set;
  assign sec_hw_set[POS_FIELD_VANISH] = vanish_set;

  // ==========================================================
  // Write-mask update; a hardware set wins over a software clear
  wire        pri_pol   = wdata_q[POS_POLARITY];
  // Secondary writes carry their own polarity bit in the same lane position
  wire        sec_pol   = wdata_q[POS_POLARITY];
  wire [6:0]  pri_mark  = wdata_q[6:0] & MASK_PRI_REQ;
  wire [4:0]  sec_mark  = wdata_q[4:0] & MASK_SEC_REQ[4:0];
  wire [6:0]  pri_sw    = pri_pol ? (pri_req_q | pri_mark) : (pri_req_q & ~pri_mark);
  wire [4:0]  sec_sw    = sec_pol ? (sec_req_q | sec_mark) : (sec_req_q & ~sec_mark);

  assign pri_req_d = (wr_pri_req ? pri_sw : pri_req_q) | pri_hw_set;
  assign sec_req_d = (wr_sec_req ? sec_sw : sec_req_q) | sec_hw_set;

  // ==========================================================
  // Combined status and pin level
  wire        pri_any   = |(pri_req_q & pri_en_q[6:0]);
  wire        sec_any   = |(sec_req_q & sec_en_q[4:0]);
  wire        irq_d     = pri_any | sec_any;
  wire        pin_level = irq_q ^ pri_en_q[POS_INVERT];
  wire        push_pull = sec_en_q[POS_DRIVE_STYLE];
  // Open drain only pulls low; a high level releases the pin
  wire        pin_out_d  = push_pull ? pin_level : 1'b0;
  wire        pin_oe_n_d = push_pull ? 1'b0 : pin_level;

  // ==========================================================
  // Read mux
  // Read-only view; a write to it answers OKAY and changes nothing
  logic [7:0] status_rd;
  always_comb
  begin
    status_rd                = 8'h00;
    status_rd[POS_STAT_IRQ]  = irq_q;
    status_rd[POS_STAT_MODE] = mode_run_q;
  end
  logic [7:0] rd_val;
  logic       rd_hit;
  always_comb
  begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    case (ar_idx)
      IDX_PRI_EN:  rd_val = pri_en_q;
      IDX_SEC_EN:  rd_val = sec_en_q;
      IDX_PRI_REQ: rd_val = {1'b0, pri_req_q};
      IDX_SEC_REQ: rd_val = {3'h0, sec_req_q};
      IDX_STATUS:  rd_val = status_rd;
      IDX_CONTROL: rd_val = control_q;
      default:     rd_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Registers and request latches
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pri_en_q  <= RST_PRI_EN;
      sec_en_q  <= RST_SEC_EN;
      pri_req_q <= RST_PRI_REQ[6:0];
      sec_req_q <= RST_SEC_REQ[4:0];
      control_q <= RST_CONTROL;
    end
    else if (clk_en)
    begin
      if (wr_pri_en)
        pri_en_q <= wdata_q;
      if (wr_sec_en)
        sec_en_q <= wdata_q & MASK_SEC_EN;
      if (wr_control)
        control_q <= {7'h00, wdata_q[POS_CTRL_CLEAN]};
      pri_req_q <= pri_req_d;
      sec_req_q <= sec_req_d;
    end
  end

  // Edge history, aux synchroniser, mode detector
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aux_sync1_q  <= 1'b0;
      aux_sync2_q  <= 1'b0;
      aux_prev_q   <= 1'b0;
      cmd_prev_q   <= CMD_IDLE;
      high_prev_q  <= 1'b0;
      low_prev_q   <= 1'b0;
      field_prev_q <= 1'b0;
      mode_run_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      aux_sync1_q  <= aux_serial_input;
      aux_sync2_q  <= aux_sync1_q;
      aux_prev_q   <= aux_sync2_q;
      cmd_prev_q   <= command_field;
      high_prev_q  <= fifo_high_status;
      low_prev_q   <= fifo_low_status;
      field_prev_q <= rf_field_present;
      if (mode_set)
        mode_run_q <= 1'b0;
      else if (auto_anticollision_command_go | (rf_reset & (command_field == CMD_AUTO_ANTICOLLISION_COMMAND)))
        mode_run_q <= 1'b1;
    end
  end

  // Pin driver; irq goes through two flops (irq_q, then the pin flop) so the pin is glitch free
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_q      <= 1'b0;
      pin_out_q  <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end
    else if (clk_en)
    begin
      irq_q      <= irq_d;
      pin_out_q  <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  // ==========================================================
  // AXI4-Lite write channel: one write in flight
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      aw_idx_q  <= 4'h0;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (aw_take)
      begin
        awready_q <= 1'b0;
        aw_idx_q  <= s_axi_awaddr[ADDR_LSB +: 4];
      end
      if (w_take)
      begin
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      // Both halves are held, so register update and response share one edge
      if (write_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_done)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel: one read in flight
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 8'h00;
    end
    else if (clk_en)
    begin
      // Data is captured at the address handshake, so a later event cannot tear it
      if (ar_take)
      begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_val;
        rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (r_done)
      begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready     = awready_q;
  assign s_axi_wready      = wready_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_arready     = arready_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rresp       = rresp_q;
  assign s_axi_rdata       = {24'h000000, rdata_q};
  assign mode_detector_run = mode_run_q;
  assign irq_pin_out       = pin_out_q;
  assign irq_pin_oe_n      = pin_oe_n_q;

endmodule // cirq_top

/* File: cirq_top_monitor.sv */
// Concurrent checks on the ports of the interrupt request block
module cirq_top_monitor
  import cirq_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [3:0]  command_field,
  input wire logic        mode_detected,
  input wire logic        mode_detector_run,
  input wire logic        irq_pin_out,
  input wire logic        irq_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Setup
  // Frozen clock enable stalls every flop, so the relations are not judged then
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);
  // ==========================================================
  // Pin
  a_pin_high_driven: assert property (irq_pin_out |-> !irq_pin_oe_n)
    else $error("pin shows high while released");
  // ==========================================================
  // Register bus
  a_b_after_take: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_busy_no_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready high during pending response");
  a_r_after_take: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while pending");
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  // ==========================================================
  // Mode detector
  a_mode_stops: assert property (mode_detected && mode_detector_run |=> !mode_detector_run)
    else $error("mode detector kept running");
  a_mode_starts: assert property ($rose(mode_detector_run) |->
    $past(command_field) == CMD_AUTO_ANTICOLLISION_COMMAND)
    else $error("mode detector started outside anticollision");
endmodule // cirq_top_monitor

/* File: cirq_host_model.sv */
// Host side of the interrupt pin: pull-up on the line and the level the host sees
module cirq_host_model
(
  input  wire logic irq_pin_out,
  input  wire logic irq_pin_oe_n,
  output logic      pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released line floats up through the host pull-up, so open drain idles high
  assign pin_level = irq_pin_oe_n ? 1'b1 : irq_pin_out;
endmodule // cirq_host_model

/* File: tb_cirq_top.sv */
// Testbench of the interrupt request block over its register bus and event inputs
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb_cirq_top
  import cirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, fifo_has_data, host_idle_write, mode_detector_run;
  logic        irq_pin_out, irq_pin_oe_n, lvl, clk_en;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  command_field;
  logic [11:0] ev;
  logic [7:0]  tx [11] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01,
                          8'h10, 8'h03, 8'h04, 8'h08};
  int          error_cnt, n_tests;
  // ==========================================================
  // Instances
  cirq_top u_cirq_top (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .send_last_bit(ev[0]), .receive_stream_end(ev[1]),
    .fifo_has_data, .command_field, .host_idle_write, .unknown_command_start(ev[2]),
    .fifo_high_status(ev[3]), .fifo_low_status(ev[4]), .error_bits({ev[5], 7'h00}),
    .countdown_reached_zero(ev[6]), .aux_serial_input(ev[7]), .rf_field_present(ev[8]),
    .checksum_all_processed(ev[9]), .mode_detected(ev[10]), .rf_reset(ev[11]),
    .mode_detector_run, .irq_pin_out, .irq_pin_oe_n);
  cirq_host_model u_cirq_host_model (.irq_pin_out, .irq_pin_oe_n, .pin_level(lvl));
  // ==========================================================
  // Tasks
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 50)
    begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [5:0] ad, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    tmo(n);
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rd(input logic [5:0] ad, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    tmo(n);
    `CHK(s_axi_rdata, {24'h000000, d})
    `CHK(s_axi_rresp, er)
  endtask
  task automatic pulse(input int i);
    @(posedge aclk);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev[i] <= 1'b0;
  endtask
  // Pin path trails the request bit by two flops
  task automatic pin(input logic o, input logic oe, input logic l);
    repeat (4) @(posedge aclk);
    `CHK({irq_pin_out, irq_pin_oe_n, lvl}, {o, oe, l})
  endtask
  // ==========================================================
  // Sequence
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {fifo_has_data, host_idle_write, s_axi_awaddr, s_axi_araddr, s_axi_wdata, ev} = '0;
    command_field = CMD_IDLE;
    clk_en = 1'b1;
    error_cnt = 0;
    n_tests = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK(irq_pin_oe_n, 1'b1)
    rd(6'h0C, 8'h00, RESP_OKAY);
    rd(6'h10, 8'h14, RESP_OKAY);
    wr(6'h10, 8'h14, RESP_OKAY);
    rd(6'h10, 8'h00, RESP_OKAY);
    wr(6'h10, 8'hC1, RESP_OKAY);
    wr(6'h10, 8'h01, RESP_OKAY);
    rd(6'h10, 8'h40, RESP_OKAY);
    wr(6'h10, 8'h40, RESP_OKAY);
    wr(6'h14, 8'h9F, RESP_OKAY);
    wr(6'h14, 8'h1A, RESP_OKAY);
    rd(6'h14, 8'h05, RESP_OKAY);
    wr(6'h14, 8'h05, RESP_OKAY);
    $display("test write mask finished");
    for (int i = 0; i < 11; i++)
    begin
      command_field <= (i == 9) ? CMD_CHECKSUM : (i == 10) ? CMD_AUTO_ANTICOLLISION_COMMAND : CMD_IDLE;
      pulse(i);
      repeat (6) @(posedge aclk);
      rd(i<7 ? 6'h10 : 6'h14, tx[i], RESP_OKAY);
      wr(i < 7 ? 6'h10 : 6'h14, tx[i], RESP_OKAY);
    end
    `CHK(mode_detector_run, 1'b0)
    pulse(11);
    @(posedge aclk);
    `CHK(mode_detector_run, 1'b1)
    $display("test events finished");
    command_field <= CMD_IDLE;
    host_idle_write <= 1'b1;
    @(posedge aclk);
    host_idle_write <= 1'b0;
    rd(6'h10, 8'h00, RESP_OKAY);
    command_field <= CMD_CHECKSUM;
    @(posedge aclk);
    command_field <= CMD_IDLE;
    rd(6'h10, 8'h10, RESP_OKAY);
    wr(6'h10, 8'h10, RESP_OKAY);
    wr(6'h20, 8'h01, RESP_OKAY);
    pulse(1);
    rd(6'h10, 8'h00, RESP_OKAY);
    fifo_has_data <= 1'b1;
    pulse(1);
    rd(6'h10, 8'h20, RESP_OKAY);
    wr(6'h10, 8'h20, RESP_OKAY);
    $display("test command and receive finished");
    wr(6'h08, 8'h40, RESP_OKAY);
    wr(6'h0C, 8'h80, RESP_OKAY);
    wr(6'h10, 8'hC0, RESP_OKAY);
    pin(1'b1, 1'b0, 1'b1);
    wr(6'h08, 8'hC0, RESP_OKAY);
    pin(1'b0, 1'b0, 1'b0);
    wr(6'h0C, 8'h00, RESP_OKAY);
    pin(1'b0, 1'b0, 1'b0);
    wr(6'h08, 8'h40, RESP_OKAY);
    pin(1'b0, 1'b1, 1'b1);
    wr(6'h08, 8'h00, RESP_OKAY);
    pin(1'b0, 1'b0, 1'b0);
    wr(6'h0C, 8'h01, RESP_OKAY);
    wr(6'h14, 8'h81, RESP_OKAY);
    pin(1'b0, 1'b1, 1'b1);
    wr(6'h1C, 8'h00, RESP_OKAY);
    rd(6'h1C, 8'h30, RESP_OKAY);
    rd(6'h20, 8'h01, RESP_OKAY);
    $display("test pin finished");
    rd(6'h3C, 8'h00, RESP_SLVERR);
    wr(6'h3C, 8'hFF, RESP_SLVERR);
    $display("test unmapped finished");
    // A frozen enable must swallow an event pulse
    clk_en <= 1'b0;
    pulse(6);
    repeat (2) @(posedge aclk);
    clk_en <= 1'b1;
    rd(6'h10, 8'h40, RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(6'h10, 8'h14, RESP_OKAY);
    rd(6'h0C, 8'h00, RESP_OKAY);
    $display("test freeze and reset finished");
    end_sim();
  end
endmodule // tb_cirq_top
bind cirq_top cirq_top_monitor u_cirq_top_monitor (.aclk, .aresetn, .clk_en, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .command_field, .mode_detected,
  .mode_detector_run, .irq_pin_out, .irq_pin_oe_n);
